// ---- fcr_pkg.sv ----
// package: feature control register constants, types and functional notes
//------------------------------------------------------------
// Functional notes
// R1: v86 extensions virtualise interrupts, redirect bitmap intercept
// R2: bit 1 enables virtual flag for sti/cli
// R3: bit 2 limits timestamp reads to level 0
// R4: bit 3 set: io breakpoints, dr4/dr5 fault
// R5: bit 3 clear: dr4/dr5 alias dr6/dr7
// R6: bit 4 selects large pages unless extended addressing
// R7: bit 5 gives 64-bit entries, 2M pages
// R8: bit 6 gates machine check exception
// R9: errors always recorded; correctable never raise exception
// R10: bit 7 keeps global translations on base rewrite
// R11: bit 8 opens perf counter read to all
// R12: bit 9 clear faults legacy simd, saves allowed
// R13: bit 10 clear reports simd fp as opcode fault
// R14: bit 11 faults table stores above level 0
// R15: bit 16 opens segment base access in 64-bit
// R16: bit 17 context ids, settable only long mode
// R17: bit 18 permits ext control and ext save
// R18: bits 20/21 guard supervisor exec and access
// R19: bit 22 rising flushes all translations
// R20: bit 23 needs write protect set, else fault
// R21: unimplemented control registers raise opcode fault
// R22: clearing write protect under shadow stack faults
// R23: reset clears all feature bits
//------------------------------------------------------------
package fcr_pkg;
    localparam int FCR_W = 64;
    localparam logic [63:0] FCR_RESET = 64'h0000000000000000;
    localparam logic [63:0] FCR_WMASK = 64'h0000000000F70FFF; // writable bits
    localparam int B_VME = 0;
    localparam int B_PVI = 1;
    localparam int B_TSD = 2;
    localparam int B_DBG = 3;
    localparam int B_LPG = 4;
    localparam int B_PAX = 5;
    localparam int B_MCK = 6;
    localparam int B_GLB = 7;
    localparam int B_PCU = 8;
    localparam int B_LSM = 9;
    localparam int B_SFX = 10;
    localparam int B_UIG = 11;
    localparam int B_SEG = 16;
    localparam int B_CID = 17;
    localparam int B_EXS = 18;
    localparam int B_SXG = 20;
    localparam int B_SAG = 21;
    localparam int B_PKY = 22;
    localparam int B_SSK = 23;
    localparam int WP_BIT = 16; // write protect in base control reg
    localparam logic [3:0] CR_FEATURE = 4'h4;
    localparam logic [3:0] CR_BASE = 4'h0;
    localparam logic [3:0] CR_PFADDR = 4'h2;
    localparam logic [3:0] CR_TABLE = 4'h3;
    localparam logic [3:0] CR_TPR = 4'h8;
    localparam logic [2:0] DR_FOUR = 3'h4;
    localparam logic [2:0] DR_FIVE = 3'h5;
    localparam logic [1:0] PL_ZERO = 2'h0;

    // control register move request
    typedef struct packed {
        logic valid;
        logic write;
        logic [3:0] idx;
        logic [63:0] data;
    } fcr_cr_req_t;

    // privilege and mode context of the instruction being checked
    typedef struct packed {
        logic [1:0] current_privilege;
        logic long_mode_active;
        logic mode64;
        logic v86_mode;
    } fcr_ctx_t;

    // instruction classes to check
    typedef struct packed {
        logic read_timestamp;
        logic read_perf_counter;
        logic table_store;
        logic segment_base;
        logic context_tlb_flush;
        logic ext_control;
        logic ext_state;
        logic legacy_simd;
        logic key_access;
        logic dr_valid;
        logic [2:0] dr_idx;
    } fcr_instr_t;

    // fault outputs
    typedef struct packed {
        logic invalid_opcode_fault;
        logic protection_fault;
        logic machine_check_fault;
        logic simd_fp_fault;
    } fcr_fault_t;
endpackage : fcr_pkg

// ---- fcr_instr_check.sv ----
// instruction permission checks driven by the feature bits
`timescale 1ns/1ps
module fcr_instr_check (
    input wire logic [63:0] feat_in,
    input wire fcr_pkg::fcr_ctx_t ctx_in,
    input wire fcr_pkg::fcr_instr_t instr_in,
    output logic ud_out,
    output logic gp_out,
    output logic [2:0] dr_eff_out,
    output logic io_bp_en_out
);
    import fcr_pkg::*;

    logic kern;

    // privilege gating per instruction class
    always_comb begin
        kern = (ctx_in.current_privilege == PL_ZERO);
        ud_out = 1'b0;
        gp_out = 1'b0;
        if (instr_in.read_timestamp && feat_in[B_TSD] && !kern) begin
            gp_out = 1'b1; // see R3
        end
        if (instr_in.read_perf_counter && !feat_in[B_PCU] && !kern) begin
            gp_out = 1'b1; // see R11
        end
        if (instr_in.table_store && feat_in[B_UIG] && !kern) begin
            gp_out = 1'b1; // see R14
        end
        if (instr_in.segment_base && !(feat_in[B_SEG] && ctx_in.mode64)) begin
            ud_out = 1'b1; // see R15
        end
        if (instr_in.context_tlb_flush && !feat_in[B_CID]) begin
            ud_out = 1'b1; // see R16
        end
        if ((instr_in.ext_control || instr_in.ext_state) && !feat_in[B_EXS]) begin
            ud_out = 1'b1; // see R17
        end
        if (instr_in.legacy_simd && !feat_in[B_LSM]) begin
            ud_out = 1'b1; // see R12
        end
        if (instr_in.key_access && !feat_in[B_PKY]) begin
            ud_out = 1'b1; // see R19
        end
        if (instr_in.dr_valid && feat_in[B_DBG] &&
            (instr_in.dr_idx == DR_FOUR || instr_in.dr_idx == DR_FIVE)) begin
            ud_out = 1'b1; // see R4
        end
    end

    // debug register aliasing
    always_comb begin
        dr_eff_out = instr_in.dr_idx;
        if (!feat_in[B_DBG] && instr_in.dr_idx == DR_FOUR) begin
            dr_eff_out = 3'h6; // see R5
        end else if (!feat_in[B_DBG] && instr_in.dr_idx == DR_FIVE) begin
            dr_eff_out = 3'h7; // see R5
        end
        io_bp_en_out = feat_in[B_DBG]; // see R4
    end
endmodule : fcr_instr_check

// ---- fcr_paging_ctl.sv ----
// paging mode and flush controls derived from the feature bits
`timescale 1ns/1ps
module fcr_paging_ctl (
    input wire logic [63:0] feat_in,
    input wire logic dir_page_size_in,
    output logic large_page_out,
    output logic wide_entries_out,
    output logic keep_global_out,
    output logic super_exec_guard_out,
    output logic super_access_guard_out
);
    import fcr_pkg::*;

    // page size selection and guards
    always_comb begin
        wide_entries_out = feat_in[B_PAX]; // see R7
        // extended addressing overrides large page bit
        large_page_out = dir_page_size_in &&
            (feat_in[B_PAX] || feat_in[B_LPG]); // see R6
        keep_global_out = feat_in[B_GLB]; // see R10
        super_exec_guard_out = feat_in[B_SXG]; // see R18
        super_access_guard_out = feat_in[B_SAG]; // see R18
    end
endmodule : fcr_paging_ctl

// ---- fcr_top.sv ----
// feature control register bank with fault generation
`timescale 1ns/1ps
module fcr_top (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire fcr_pkg::fcr_cr_req_t req_in,
    input wire logic [63:0] base_ctl_in,
    input wire fcr_pkg::fcr_ctx_t ctx_in,
    input wire fcr_pkg::fcr_instr_t instr_in,
    input wire logic dir_page_size_in,
    input wire logic table_base_write_in,
    input wire logic mc_uncorrectable_in,
    input wire logic mc_correctable_in,
    input wire logic simd_fp_unmasked_in,
    input wire logic sti_cli_in,
    input wire logic soft_int_in,
    output logic [63:0] feature_control_reg_out,
    output logic [63:0] rdata_out,
    output fcr_pkg::fcr_fault_t fault_out,
    output logic [2:0] dr_eff_out,
    output logic io_bp_en_out,
    output logic large_page_out,
    output logic wide_entries_out,
    output logic super_exec_guard_out,
    output logic super_access_guard_out,
    output logic tlb_flush_all_out,
    output logic tlb_flush_nonglobal_out,
    output logic mc_record_out,
    output logic virt_int_hw_out,
    output logic redirect_bitmap_out
);
    import fcr_pkg::*;

    //------------------------------------------------------------
    // state
    //------------------------------------------------------------
    logic [63:0] feat;
    logic [63:0] next_feat;
    logic [63:0] rdata;
    logic [63:0] next_rdata;
    fcr_fault_t fault;
    fcr_fault_t next_fault;
    logic flush_all;
    logic next_flush_all;
    logic flush_ng;
    logic next_flush_ng;
    logic mc_rec;
    logic next_mc_rec;
    logic chk_ud;
    logic chk_gp;
    logic [63:0] wval;
    logic wr_feat;
    logic rd_feat;
    logic cr_bad;
    logic wr_gp;
    logic keep_global;

    //------------------------------------------------------------
    // submodules
    //------------------------------------------------------------
    fcr_instr_check u_check (
        .feat_in(feat),
        .ctx_in(ctx_in),
        .instr_in(instr_in),
        .ud_out(chk_ud),
        .gp_out(chk_gp),
        .dr_eff_out(dr_eff_out),
        .io_bp_en_out(io_bp_en_out)
    );

    fcr_paging_ctl u_paging (
        .feat_in(feat),
        .dir_page_size_in(dir_page_size_in),
        .large_page_out(large_page_out),
        .wide_entries_out(wide_entries_out),
        .keep_global_out(keep_global),
        .super_exec_guard_out(super_exec_guard_out),
        .super_access_guard_out(super_access_guard_out)
    );

    //------------------------------------------------------------
    // register write and fault logic
    //------------------------------------------------------------
    // decode control register move and compute checks
    always_comb begin
        wval = req_in.data & FCR_WMASK;
        wr_feat = req_in.valid && req_in.write && req_in.idx == CR_FEATURE;
        rd_feat = req_in.valid && !req_in.write && req_in.idx == CR_FEATURE;
        cr_bad = req_in.valid && !(req_in.idx == CR_BASE || req_in.idx == CR_PFADDR ||
            req_in.idx == CR_TABLE || req_in.idx == CR_FEATURE ||
            req_in.idx == CR_TPR); // see R21
        wr_gp = 1'b0;
        if (wr_feat && req_in.data[B_CID] && !ctx_in.long_mode_active) begin
            wr_gp = 1'b1; // see R16
        end
        if (wr_feat && req_in.data[B_SSK] && !base_ctl_in[WP_BIT]) begin
            wr_gp = 1'b1; // see R20
        end
        if (wr_feat && (req_in.data & ~FCR_WMASK) != 64'h0000000000000000) begin
            wr_gp = 1'b1; // reserved bits must be zero
        end
        if (req_in.valid && req_in.write && req_in.idx == CR_BASE &&
            feat[B_SSK] && !req_in.data[WP_BIT]) begin
            wr_gp = 1'b1; // see R22
        end
    end

    // next state for register, read data, faults and flushes
    always_comb begin
        next_feat = feat;
        next_rdata = rdata;
        next_flush_all = 1'b0;
        next_flush_ng = 1'b0;
        if (wr_feat && !wr_gp) begin
            next_feat = wval;
            next_flush_all = !feat[B_PKY] && wval[B_PKY]; // see R19
        end
        if (rd_feat) begin
            next_rdata = feat;
        end
        if (table_base_write_in && !next_flush_all) begin
            // global entries kept only with global enable
            next_flush_ng = keep_global; // see R10
            next_flush_all = !keep_global;
        end
        next_fault.invalid_opcode_fault = cr_bad || chk_ud ||
            (simd_fp_unmasked_in && !feat[B_SFX]); // see R13
        next_fault.protection_fault = wr_gp || chk_gp;
        next_fault.machine_check_fault = mc_uncorrectable_in && feat[B_MCK]; // see R8
        next_fault.simd_fp_fault = simd_fp_unmasked_in && feat[B_SFX];
        next_mc_rec = mc_uncorrectable_in || mc_correctable_in; // see R9
    end

    // registers, cleared on reset
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            feat <= FCR_RESET; // see R23
            rdata <= FCR_RESET;
            fault <= '0;
            flush_all <= 1'b0;
            flush_ng <= 1'b0;
            mc_rec <= 1'b0;
        end else begin
            feat <= next_feat;
            rdata <= next_rdata;
            fault <= next_fault;
            flush_all <= next_flush_all;
            flush_ng <= next_flush_ng;
            mc_rec <= next_mc_rec;
        end
    end

    //------------------------------------------------------------
    // outputs
    //------------------------------------------------------------
    // virtual interrupt steering
    always_comb begin
        virt_int_hw_out = (ctx_in.v86_mode && feat[B_VME]) ||
            (!ctx_in.v86_mode && feat[B_PVI] && sti_cli_in); // see R1 see R2
        redirect_bitmap_out = ctx_in.v86_mode && feat[B_VME] && soft_int_in; // see R1
    end

    assign feature_control_reg_out = feat;
    assign rdata_out = rdata;
    assign fault_out = fault;
    assign tlb_flush_all_out = flush_all;
    assign tlb_flush_nonglobal_out = flush_ng;
    assign mc_record_out = mc_rec;

    //------------------------------------------------------------
    // assertions
    //------------------------------------------------------------
    property p_reset_clear;
        @(posedge sys_clk_in) $past(rst_in) |-> feat == 64'h0000000000000000;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("not cleared"); // see R23

    property p_pke_flush;
        @(posedge sys_clk_in) disable iff (rst_in)
        (wr_feat && !wr_gp && !feat[B_PKY] && req_in.data[B_PKY]) |=> tlb_flush_all_out;
    endproperty
    a_pke_flush: assert property (p_pke_flush) else $error("no flush"); // see R19

    property p_cet_gp;
        @(posedge sys_clk_in) disable iff (rst_in)
        (wr_feat && req_in.data[B_SSK] && !base_ctl_in[WP_BIT])
            |=> fault_out.protection_fault && $stable(feat);
    endproperty
    a_cet_gp: assert property (p_cet_gp) else $error("shadow set"); // see R20

    property p_wp_clear_gp;
        @(posedge sys_clk_in) disable iff (rst_in)
        (req_in.valid && req_in.write && req_in.idx == CR_BASE && feat[B_SSK]
            && !req_in.data[WP_BIT]) |=> fault_out.protection_fault;
    endproperty
    a_wp_clear_gp: assert property (p_wp_clear_gp) else $error("wp clear ok"); // see R22

    property p_pcid_lm;
        @(posedge sys_clk_in) disable iff (rst_in)
        (wr_feat && req_in.data[B_CID] && !ctx_in.long_mode_active)
            |=> fault_out.protection_fault && $stable(feat);
    endproperty
    a_pcid_lm: assert property (p_pcid_lm) else $error("pcid outside long"); // see R16

    property p_mc;
        @(posedge sys_clk_in) disable iff (rst_in)
        mc_correctable_in && !mc_uncorrectable_in |=> mc_record_out && !fault_out.machine_check_fault;
    endproperty
    a_mc: assert property (p_mc) else $error("correctable raised"); // see R9

    property p_bad_cr;
        @(posedge sys_clk_in) disable iff (rst_in)
        (req_in.valid && req_in.idx == 4'h5) |=> fault_out.invalid_opcode_fault;
    endproperty
    a_bad_cr: assert property (p_bad_cr) else $error("cr5 no fault"); // see R21

    property p_tsd;
        @(posedge sys_clk_in) disable iff (rst_in)
        (instr_in.read_timestamp && feat[B_TSD] && ctx_in.current_privilege != 2'h0)
            |=> fault_out.protection_fault;
    endproperty
    a_tsd: assert property (p_tsd) else $error("timestamp allowed"); // see R3

    property p_alias;
        @(posedge sys_clk_in) disable iff (rst_in)
        (!feat[B_DBG] && instr_in.dr_idx == 3'h4) |-> dr_eff_out == 3'h6;
    endproperty
    a_alias: assert property (p_alias) else $error("no alias"); // see R5

    // uncorrectable errors raise the exception only with the enable bit
    property p_mc_raise;
        @(posedge sys_clk_in) disable iff (rst_in)
        mc_uncorrectable_in |=> fault_out.machine_check_fault == $past(feat[B_MCK]);
    endproperty
    a_mc_raise: assert property (p_mc_raise) else $error("machine check wrong"); // see R8

    // table base rewrite keeps global entries when enabled
    property p_global_keep;
        @(posedge sys_clk_in) disable iff (rst_in)
        (table_base_write_in && feat[B_GLB] && !wr_feat)
            |=> tlb_flush_nonglobal_out && !tlb_flush_all_out;
    endproperty
    a_global_keep: assert property (p_global_keep) else $error("global flushed"); // see R10

    // unsupported simd fp handler turns exception into opcode fault
    property p_simd_fp;
        @(posedge sys_clk_in) disable iff (rst_in)
        (simd_fp_unmasked_in && !feat[B_SFX])
            |=> fault_out.invalid_opcode_fault && !fault_out.simd_fp_fault;
    endproperty
    a_simd_fp: assert property (p_simd_fp) else $error("simd fp not converted"); // see R13

    // perf counter read outside level zero needs the open bit
    property p_perf;
        @(posedge sys_clk_in) disable iff (rst_in)
        (instr_in.read_perf_counter && !feat[B_PCU] && ctx_in.current_privilege != 2'h0)
            |=> fault_out.protection_fault;
    endproperty
    a_perf: assert property (p_perf) else $error("perf read allowed"); // see R11

    // table stores above level zero refused under the guard
    property p_user_info_guard;
        @(posedge sys_clk_in) disable iff (rst_in)
        (instr_in.table_store && feat[B_UIG] && ctx_in.current_privilege != 2'h0)
            |=> fault_out.protection_fault;
    endproperty
    a_user_info_guard: assert property (p_user_info_guard) else $error("table store allowed"); // see R14

    // legacy simd refused without its enable
    property p_legacy_simd;
        @(posedge sys_clk_in) disable iff (rst_in)
        (instr_in.legacy_simd && !feat[B_LSM]) |=> fault_out.invalid_opcode_fault;
    endproperty
    a_legacy_simd: assert property (p_legacy_simd) else $error("simd allowed"); // see R12

    // debug register five reserved with io breakpoints on
    property p_dr_reserved;
        @(posedge sys_clk_in) disable iff (rst_in)
        (instr_in.dr_valid && feat[B_DBG] && instr_in.dr_idx == 3'h5)
            |=> fault_out.invalid_opcode_fault;
    endproperty
    a_dr_reserved: assert property (p_dr_reserved) else $error("dr5 allowed"); // see R4

    // extended control and state instructions need their enable
    property p_ext_state;
        @(posedge sys_clk_in) disable iff (rst_in)
        ((instr_in.ext_control || instr_in.ext_state) && !feat[B_EXS])
            |=> fault_out.invalid_opcode_fault;
    endproperty
    a_ext_state: assert property (p_ext_state) else $error("ext state allowed"); // see R17
endmodule : fcr_top

// ---- fcr_top_tb.sv ----
// self-checking testbench for the feature control register bank
`timescale 1ns/1ps
module fcr_top_tb;
    import fcr_pkg::*;
    //------------------------------------------------------------
    // clock, stimulus and model state
    //------------------------------------------------------------
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    fcr_cr_req_t req_in = '0;
    logic [63:0] base_ctl_in = '0;
    fcr_ctx_t ctx_in = '0;
    fcr_instr_t instr_in = '0;
    logic dir_page_size_in = 1'b0;
    logic table_base_write_in = 1'b0;
    logic mc_uncorrectable_in = 1'b0;
    logic mc_correctable_in = 1'b0;
    logic simd_fp_unmasked_in = 1'b0;
    logic sti_cli_in = 1'b0;
    logic soft_int_in = 1'b0;
    logic [63:0] feature_control_reg_out;
    logic [63:0] rdata_out;
    fcr_fault_t fault_out;
    logic [2:0] dr_eff_out;
    logic io_bp_en_out, large_page_out, wide_entries_out;
    logic super_exec_guard_out, super_access_guard_out;
    logic tlb_flush_all_out, tlb_flush_nonglobal_out, mc_record_out;
    logic virt_int_hw_out, redirect_bitmap_out;
    logic [63:0] m_feat = '0;
    int n_fail = 0;
    int total_checks = 0;
    int seed_ret;
    logic [63:0] d;

    always #4 sys_clk_in = ~sys_clk_in;

    fcr_top i_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .req_in(req_in),
        .base_ctl_in(base_ctl_in), .ctx_in(ctx_in), .instr_in(instr_in),
        .dir_page_size_in(dir_page_size_in), .table_base_write_in(table_base_write_in),
        .mc_uncorrectable_in(mc_uncorrectable_in), .mc_correctable_in(mc_correctable_in),
        .simd_fp_unmasked_in(simd_fp_unmasked_in), .sti_cli_in(sti_cli_in),
        .soft_int_in(soft_int_in), .feature_control_reg_out(feature_control_reg_out),
        .rdata_out(rdata_out), .fault_out(fault_out), .dr_eff_out(dr_eff_out),
        .io_bp_en_out(io_bp_en_out), .large_page_out(large_page_out),
        .wide_entries_out(wide_entries_out), .super_exec_guard_out(super_exec_guard_out),
        .super_access_guard_out(super_access_guard_out),
        .tlb_flush_all_out(tlb_flush_all_out),
        .tlb_flush_nonglobal_out(tlb_flush_nonglobal_out), .mc_record_out(mc_record_out),
        .virt_int_hw_out(virt_int_hw_out), .redirect_bitmap_out(redirect_bitmap_out));

    //------------------------------------------------------------
    // compare, verdict and bus tasks
    //------------------------------------------------------------
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    // one control register move, model updated alongside
    task automatic cr(input logic wr, input logic [3:0] idx, input logic [63:0] dat);
        logic ud, gp, fl;
        ud = !(idx inside {CR_BASE, CR_PFADDR, CR_TABLE, CR_FEATURE, CR_TPR});
        gp = 1'b0;
        fl = 1'b0;
        if (wr && idx == CR_FEATURE) begin
            gp = (|(dat & ~FCR_WMASK)) || (dat[B_CID] && !ctx_in.long_mode_active)
                || (dat[B_SSK] && !base_ctl_in[WP_BIT]);
            if (!gp) begin
                fl = dat[B_PKY] & ~m_feat[B_PKY];
                m_feat = dat;
            end
        end
        if (wr && idx == CR_BASE && !dat[WP_BIT] && m_feat[B_SSK])
            gp = 1'b1;
        req_in = {1'b1, wr, idx, dat};
        @(negedge sys_clk_in);
        req_in.valid = 1'b0;
        chk("cr_fault", {60'h0, ud, gp, 2'b00}, {60'h0, fault_out});
        chk("feature", m_feat, feature_control_reg_out);
        chk("flush_all", {63'h0, fl}, {63'h0, tlb_flush_all_out});
        if (!wr && idx == CR_FEATURE)
            chk("rdata", m_feat, rdata_out);
        @(negedge sys_clk_in);
    endtask : cr

    // one instruction class checked at a given privilege
    task automatic ins(input int k, input logic [1:0] current_privilege);
        fcr_instr_t i;
        logic ud, gp, up;
        i = '0;
        ud = 1'b0;
        gp = 1'b0;
        up = (current_privilege != PL_ZERO);
        ctx_in.current_privilege = current_privilege;
        case (k)
            0: begin i.read_timestamp = 1'b1; gp = m_feat[B_TSD] && up; end
            1: begin i.read_perf_counter = 1'b1; gp = !m_feat[B_PCU] && up; end
            2: begin i.table_store = 1'b1; gp = m_feat[B_UIG] && up; end
            3: begin i.segment_base = 1'b1; ud = !(m_feat[B_SEG] && ctx_in.mode64); end
            4: begin i.context_tlb_flush = 1'b1; ud = !m_feat[B_CID]; end
            5: begin i.ext_control = 1'b1; ud = !m_feat[B_EXS]; end
            6: begin i.ext_state = 1'b1; ud = !m_feat[B_EXS]; end
            7: begin i.legacy_simd = 1'b1; ud = !m_feat[B_LSM]; end
            8: begin i.key_access = 1'b1; ud = !m_feat[B_PKY]; end
            default: begin
                i.dr_valid = 1'b1;
                i.dr_idx = (k == 9) ? DR_FOUR : DR_FIVE;
                ud = m_feat[B_DBG];
            end
        endcase
        instr_in = i;
        #1;
        if (k >= 9)
            chk("dr_eff", {61'h0, m_feat[B_DBG] ? i.dr_idx : i.dr_idx + 3'h2},
                {61'h0, dr_eff_out});
        @(negedge sys_clk_in);
        instr_in = '0;
        chk("ins_fault", {60'h0, ud, gp, 2'b00}, {60'h0, fault_out});
        @(negedge sys_clk_in);
    endtask : ins

    // event inputs: table base rewrite, machine errors, simd fp exception
    task automatic ev(input logic [3:0] e);
        {table_base_write_in, mc_uncorrectable_in, mc_correctable_in, simd_fp_unmasked_in} = e;
        @(negedge sys_clk_in);
        {table_base_write_in, mc_uncorrectable_in, mc_correctable_in, simd_fp_unmasked_in} = '0;
        chk("flush_ng", {63'h0, e[3] & m_feat[B_GLB]}, {63'h0, tlb_flush_nonglobal_out});
        chk("flush_all", {63'h0, e[3] & !m_feat[B_GLB]}, {63'h0, tlb_flush_all_out});
        chk("mc_record", {63'h0, e[2] | e[1]}, {63'h0, mc_record_out});
        chk("ev_fault", {60'h0, e[0] & !m_feat[B_SFX], 1'b0, e[2] & m_feat[B_MCK],
            e[0] & m_feat[B_SFX]}, {60'h0, fault_out});
    endtask : ev

    // combinational steering outputs against the model register
    task automatic comb();
        dir_page_size_in = 1'($urandom);
        sti_cli_in = 1'($urandom);
        soft_int_in = 1'($urandom);
        ctx_in.v86_mode = 1'b0;
        #1;
        chk("io_bp", {63'h0, m_feat[B_DBG]}, {63'h0, io_bp_en_out});
        chk("large", {63'h0, (m_feat[B_LPG] | m_feat[B_PAX]) & dir_page_size_in},
            {63'h0, large_page_out});
        chk("wide", {63'h0, m_feat[B_PAX]}, {63'h0, wide_entries_out});
        chk("sxg", {63'h0, m_feat[B_SXG]}, {63'h0, super_exec_guard_out});
        chk("sag", {63'h0, m_feat[B_SAG]}, {63'h0, super_access_guard_out});
        chk("virt_int", {63'h0, m_feat[B_PVI] & sti_cli_in}, {63'h0, virt_int_hw_out});
        ctx_in.v86_mode = 1'b1;
        #1;
        chk("redirect", {63'h0, m_feat[B_VME] & soft_int_in},
            {63'h0, redirect_bitmap_out});
        chk("virt_int_v86", {63'h0, m_feat[B_VME]}, {63'h0, virt_int_hw_out});
    endtask : comb

    //------------------------------------------------------------
    // main sequence and watchdog
    //------------------------------------------------------------
    initial begin
        #(20000 * 8);
        n_fail++;
        close_out();
    end

    initial begin
        ctx_in.mode64 = 1'b1;
        repeat (12) @(negedge sys_clk_in);
        rst_in = 1'b0;
        seed_ret = $urandom(1153);
        chk("reset_feat", 64'h0, feature_control_reg_out);
        cr(1'b0, CR_FEATURE, 64'h0);
        for (int j = 0; j < 40; j++) begin
            ctx_in.long_mode_active = 1'($urandom);
            ctx_in.mode64 = 1'($urandom);
            base_ctl_in = {$urandom, $urandom};
            d = {$urandom, $urandom} & FCR_WMASK;
            if (j % 5 == 0)
                d[30] = 1'b1;
            cr(1'b1, CR_FEATURE, d);
            comb();
            for (int k = 0; k < 11; k++)
                ins(k, 2'($urandom));
            ev(4'($urandom));
            cr(1'b0, CR_FEATURE, 64'h0);
        end
        for (int x = 0; x < 16; x++)
            cr(1'b0, 4'(x), 64'h0);
        ctx_in.long_mode_active = 1'b1;
        base_ctl_in = 64'h0000000000010000;
        cr(1'b1, CR_FEATURE, 64'h0);
        cr(1'b1, CR_FEATURE, 64'h0000000000C00000);
        cr(1'b1, CR_BASE, 64'h0);
        base_ctl_in = 64'h0;
        cr(1'b1, CR_FEATURE, 64'h0000000000800000);
        cr(1'b1, CR_FEATURE, 64'h0);
        cr(1'b1, CR_FEATURE, 64'h0000000000800000);
        ctx_in.long_mode_active = 1'b0;
        cr(1'b1, CR_FEATURE, 64'h0000000000020000);
        rst_in = 1'b1;
        repeat (2) @(negedge sys_clk_in);
        rst_in = 1'b0;
        m_feat = '0;
        chk("reset_again", 64'h0, feature_control_reg_out);
        close_out();
    end
endmodule : fcr_top_tb
